// File: shpws_port.sv
/*
 * Host read path of the scan-bus master: asynchronous host strobe,
 * hardware wait states on an empty scan-input buffer, status polling,
 * and the test access port output enable.
 * Assumes scan processing pushes bytes on mclk and the host honours ready.
 */
`timescale 1ns/1ps
`default_nettype none
module shpws_port #(
    parameter int unsigned BUF_W = shpws_pkg::DATA_W,
    parameter int unsigned BUF_D = shpws_pkg::BUF_DEPTH
) (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire shpws_pkg::shpws_host_s host_in,
    output shpws_pkg::shpws_answer_s   host_out,
    input  wire logic                  scan_in_valid,
    output logic                       scan_in_ready,
    input  wire logic [BUF_W-1:0]      scan_in_data,
    input  wire logic                  test_port_output_enable_n,
    input  wire logic                  tck_int,
    input  wire logic                  tms_int,
    input  wire logic                  tdo_int,
    input  wire logic                  trst_int,
    output logic [3:0]                 tap_out,
    output logic [3:0]                 tap_oe
);
    import shpws_pkg::*;

    typedef struct packed {
        shpws_host_s       sync1;
        shpws_host_s       sync2;
        logic              toe_s1;
        logic              toe_s2;
        shpws_state_e      state;
        logic [BUF_W-1:0]  data;
        logic              data_oe;
        logic              ready;
        logic              tap_en;
        logic [3:0]        tap_q;
    } shpws_port_s;

    shpws_port_s st_reg;
    shpws_port_s st_next;
    logic             buf_valid;
    logic             buf_pop;
    logic [BUF_W-1:0] buf_data;

    shpws_buf #(
        .WIDTH (BUF_W),
        .DEPTH (BUF_D)
    ) u_buf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (scan_in_valid),
        .in_ready  (scan_in_ready),
        .in_data   (scan_in_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    function automatic logic is_read(input shpws_host_s h, input logic [2:0] a);
        return !h.strobe_n && h.read_n_write && (h.addr == a);
    endfunction : is_read

    ////////////////////////////////////////////////////////////////////////////
    // Host access sequencer
    always_comb begin
        st_next        = st_reg;
        buf_pop        = 1'b0;
        st_next.sync1  = host_in;
        st_next.sync2  = st_reg.sync1;
        st_next.toe_s1 = test_port_output_enable_n;
        st_next.toe_s2 = st_reg.toe_s1;
        st_next.tap_en = !st_reg.toe_s2;
        st_next.tap_q  = {trst_int, tdo_int, tms_int, tck_int};
        case (st_reg.state)
            SHPWS_IDLE: begin
                st_next.ready = 1'b1;
                if (is_read(st_reg.sync2, ADDR_SCAN_IN)) begin
                    st_next.data_oe = 1'b1;
                    if (buf_valid) begin
                        st_next.data  = buf_data;
                        buf_pop       = 1'b1;
                        st_next.state = SHPWS_DRIVE;
                    end else begin
                        st_next.ready = 1'b0;
                        st_next.state = SHPWS_STALL;
                    end
                end else if (is_read(st_reg.sync2, ADDR_STATUS)) begin
                    st_next.data_oe = 1'b1;
                    st_next.data    = RESET_DATA;
                    st_next.data[STATUS_RDY_BIT] = buf_valid;
                    st_next.state   = SHPWS_DRIVE;
                end else if (!st_reg.sync2.strobe_n) begin
                    st_next.state = SHPWS_DONE;
                end
            end
            SHPWS_STALL: begin
                if (st_reg.sync2.strobe_n) begin
                    st_next.ready   = 1'b1;
                    st_next.data_oe = 1'b0;
                    st_next.state   = SHPWS_IDLE;
                end else if (buf_valid) begin
                    st_next.data  = buf_data;
                    st_next.ready = 1'b1;
                    buf_pop       = 1'b1;
                    st_next.state = SHPWS_DRIVE;
                end
            end
            SHPWS_DRIVE: begin
                if (st_reg.sync2.strobe_n) begin
                    st_next.data_oe = 1'b0;
                    st_next.state   = SHPWS_IDLE;
                end
            end
            SHPWS_DONE: begin
                if (st_reg.sync2.strobe_n) begin
                    st_next.state = SHPWS_IDLE;
                end
            end
            default: begin
                st_next.state = SHPWS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg         <= '0;
            st_reg.sync1   <= '1;
            st_reg.sync2   <= '1;
            st_reg.toe_s1  <= 1'b1;
            st_reg.toe_s2  <= 1'b1;
            st_reg.state   <= SHPWS_IDLE;
            st_reg.ready   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign host_out.data    = st_reg.data;
    assign host_out.data_oe = st_reg.data_oe;
    assign host_out.ready   = st_reg.ready;
    assign tap_out          = st_reg.tap_q;
    assign tap_oe           = {4{st_reg.tap_en}};
endmodule : shpws_port
`default_nettype wire

// File: shpws_pkg.sv
/*
 * Package for the scan host port wait-state block: register addresses,
 * status bit layout, state encoding and carrier structs.
 * Assumes nothing of its surroundings.
 */
package shpws_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned ADDR_W        = 3;
    localparam logic [2:0]  ADDR_STATUS   = 3'h0;
    localparam logic [2:0]  ADDR_SCAN_IN  = 3'h1;
    localparam int unsigned STATUS_RDY_BIT = 7;
    localparam logic [7:0]  RESET_DATA    = 8'h00;
    localparam int unsigned BUF_DEPTH     = 2;

    typedef enum logic [3:0] {
        SHPWS_IDLE  = 4'h1,
        SHPWS_STALL = 4'h2,
        SHPWS_DRIVE = 4'h4,
        SHPWS_DONE  = 4'h8
    } shpws_state_e;

    typedef struct packed {
        logic              strobe_n;
        logic              read_n_write;
        logic [ADDR_W-1:0] addr;
    } shpws_host_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              data_oe;
        logic              ready;
    } shpws_answer_s;
endpackage : shpws_pkg

// File: shpws_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock domain shared by filler and drainer.
 */
`timescale 1ns/1ps
`default_nettype none
module shpws_buf #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import shpws_pkg::*;
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [PW:0]                 count;
    } shpws_buf_s;

    shpws_buf_s st_reg;
    shpws_buf_s st_next;
    logic       push;
    logic       pop;

    assign in_ready  = (st_reg.count != (PW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data  = st_reg.mem[st_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wptr] = in_data;
            st_next.wptr = (st_reg.wptr == PW'(DEPTH-1)) ? '0 : st_reg.wptr + PW'(1);
        end
        if (pop) begin
            st_next.rptr = (st_reg.rptr == PW'(DEPTH-1)) ? '0 : st_reg.rptr + PW'(1);
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + (PW+1)'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - (PW+1)'(1);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : shpws_buf
`default_nettype wire

// File: shpws_port_props.sv
/* Checker of the host port timing.
   Sees only the ports of shpws_port; bound below. */
`timescale 1ns/1ps
`default_nettype none
module shpws_port_props
    import shpws_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     rstn,
    input wire shpws_pkg::shpws_host_s   host_in,
    input wire shpws_pkg::shpws_answer_s host_out,
    input wire logic                     scan_in_valid,
    input wire logic                     scan_in_ready,
    input wire logic [7:0]               scan_in_data,
    input wire logic                     test_port_output_enable_n,
    input wire logic [3:0]               tap_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic       rd_scan;
    logic [7:0] last_reg;
    assign rd_scan = !host_in.strobe_n && host_in.read_n_write && host_in.addr == ADDR_SCAN_IN;
    // Last byte taken, expected on the bus when a stall ends
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) last_reg <= 8'h00;
        else if (scan_in_valid && scan_in_ready) last_reg <= scan_in_data;
    end
    chk_ready_low_cause: assert property (
        $fell(host_out.ready) |-> rd_scan && $past(rd_scan, 2)) else $error("wait without read");
    chk_answer_time: assert property (
        $fell(host_in.strobe_n) && host_in.read_n_write && host_in.addr == ADDR_SCAN_IN
        |-> ##[2:4] (host_out.data_oe || !host_out.ready)) else $error("no answer");
    chk_stall_release: assert property (
        rd_scan && !host_out.ready && scan_in_valid && scan_in_ready
        |-> ##[1:3] host_out.ready) else $error("stall not released");
    chk_stall_data: assert property (
        $rose(host_out.ready) |-> host_out.data_oe && host_out.data == last_reg)
        else $error("wrong byte after stall");
    chk_write_quiet: assert property (
        $fell(host_in.strobe_n) && !host_in.read_n_write
        |-> (host_out.ready && !host_out.data_oe)[*5]) else $error("write answered");
    chk_oe_release: assert property (
        $rose(host_in.strobe_n) |-> ##[2:4] !host_out.data_oe) else $error("bus held");
    chk_tap_enable: assert property (
        $stable(test_port_output_enable_n)[*5] |-> tap_oe == {4{!test_port_output_enable_n}})
        else $error("tap enable wrong");
endmodule : shpws_port_props
bind shpws_port shpws_port_props u_props (.mclk, .rstn, .host_in, .host_out, .scan_in_valid,
    .scan_in_ready, .scan_in_data, .test_port_output_enable_n, .tap_oe);
`default_nettype wire

// File: shpws_host_model.sv
/* Host processor model on the strobe side.
   Assumes callers run access() from the bench. */
`timescale 1ns/1ps
`default_nettype none
module shpws_host_model
    import shpws_pkg::*;
(
    input  wire logic                     mclk,
    output var shpws_pkg::shpws_host_s    host_in,
    input  wire shpws_pkg::shpws_answer_s host_out
);
    initial host_in = '{strobe_n: 1'b1, read_n_write: 1'b1, addr: 3'h7};
    task automatic access(input logic rd, input logic [2:0] a, output logic [7:0] d,
                          output logic ok);
        int n;
        ok = 1'b0;
        @(negedge mclk);
        host_in = '{strobe_n: 1'b0, read_n_write: rd, addr: a};
        for (n = 0; n < (rd ? 40 : 6) && !ok; n++) begin
            @(negedge mclk);
            ok = rd && host_out.data_oe && host_out.ready;
        end
        d = host_out.data;
        host_in = '{strobe_n: 1'b1, read_n_write: !rd, addr: ~a};
        repeat (4) @(negedge mclk);
    endtask : access
endmodule : shpws_host_model
`default_nettype wire

// File: shpws_port_tb.sv
/* Self-checking bench of shpws_port with the host model.
   Assumes the 10 MHz mclk of the design. */
`timescale 1ns/1ps
`default_nettype none
module shpws_port_tb;
    import shpws_pkg::*;
    logic          mclk, rstn, scan_in_valid, scan_in_ready, enable_n, ok, took;
    logic [7:0]    scan_in_data, b0, b1, d;
    logic [3:0]    tap_int, tap_out, tap_oe;
    shpws_host_s   host_in;
    shpws_answer_s host_out;
    int            err_count, n_checks, i;
    shpws_host_model host (.mclk, .host_in, .host_out);
    shpws_port uut (.mclk, .rstn, .host_in, .host_out, .scan_in_valid, .scan_in_ready,
        .scan_in_data, .test_port_output_enable_n(enable_n), .tck_int(tap_int[0]),
        .tms_int(tap_int[1]), .tdo_int(tap_int[2]), .trst_int(tap_int[3]), .tap_out, .tap_oe);
    function automatic logic [7:0] status_exp(input int cnt);
        return (cnt > 0) ? 8'h80 : 8'h00;
    endfunction : status_exp
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic rd(input logic [2:0] a, input logic want);
        host.access(1'b1, a, d, ok);
        check("answer", {7'h0, ok}, {7'h0, want});
        if (ok !== want) begin
            stop_test();
        end
    endtask : rd
    task automatic push(input logic [7:0] b);
        @(negedge mclk);
        scan_in_valid = 1'b1;
        scan_in_data = b;
        #1 took = scan_in_ready;
        @(negedge mclk);
        scan_in_valid = 1'b0;
        scan_in_data = ~b;
    endtask : push
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        void'($urandom(86256));
        {rstn, scan_in_valid, scan_in_data, enable_n, tap_int} = '0;
        err_count = 0;
        n_checks = 0;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        for (i = 0; i < 3; i++) begin
            b0 = 8'($urandom);
            b1 = 8'($urandom);
            rd(ADDR_STATUS, 1'b1);
            check("status empty", d, status_exp(0));
            push(b0);
            push(b1);
            push(~b1);
            check("full refuse", {7'h0, took}, 8'h00);
            rd(ADDR_STATUS, 1'b1);
            check("status ready", d, status_exp(2));
            rd(ADDR_SCAN_IN, 1'b1);
            check("first byte", d, b0);
            rd(ADDR_SCAN_IN, 1'b1);
            check("second byte", d, b1);
        end
        $display("test buffer done");
        for (i = 0; i < 3; i++) begin
            b0 = 8'($urandom);
            fork
                rd(ADDR_SCAN_IN, 1'b1);
                begin
                    repeat (5 + i) @(negedge mclk);
                    check("wait state", {7'h0, host_out.ready}, 8'h00);
                    push(b0);
                end
            join
            check("stalled byte", d, b0);
        end
        $display("test stall done");
        host.access(1'b0, ADDR_SCAN_IN, d, ok);
        check("write ready", {7'h0, host_out.ready}, 8'h01);
        check("write oe", {7'h0, host_out.data_oe}, 8'h00);
        rd(3'h5, 1'b0);
        $display("test refuse done");
        for (i = 0; i < 8; i++) begin
            @(negedge mclk);
            enable_n = 1'($urandom);
            tap_int = 4'($urandom);
            repeat (4) @(negedge mclk);
            check("tap enable", {4'h0, tap_oe}, {4'h0, {4{~enable_n}}});
            check("tap level", {4'h0, tap_out}, {4'h0, tap_int});
        end
        $display("test tap done");
        stop_test();
    end
endmodule : shpws_port_tb
`default_nettype wire
